// ---- hdl/kbd_legacy_pkg.sv ----
// Functional notes
// - Aux hardware mode high: aux data write at 10Ch sets aux output-full.
// - Aux hardware mode low: aux output-full is a plain read/write user bit.
// - Irq gate set passes keyboard output-full and aux data-write flag to interrupts; clear drives low.
// - Keyboard flag select high: keyboard line follows firmware latch at 114h.
// - Keyboard flag select low: keyboard line follows writes to data at 100h.
// - Firmware assist one: firmware bit directly drives the address-20 gate.
// - Firmware assist zero: gate follows host latch or set/clear strobes.
// - Legacy port register uses io-block reset; others use system reset.
// - Legacy port register clears to 00h while io-block reset is asserted.
// - Legacy port register decodes at fixed host I/O address 92h.
// - Host accesses to port 92h answered only while port enable is set.
// - Disabled port: writes ignored, reads leave data bus undriven.
// - Port enable at config index 30h and offset 330h, bit 0 only.
// - Writing fast reset one: wait 14 us, pulse reset low at least 6 us.
// - No further reset pulse until fast reset bit written back to zero.
// - Enabled port, firmware assist zero: gate high if alt bit one; low if alt and latch zero.
// - Any write to set strobe 108h sets host address-20 latch.
// - Any write to clear strobe 10Ch clears host address-20 latch.
// - Command D1 then data copies data bit 1 into latch, no flags raised.
package kbd_legacy_pkg;
  localparam logic [9:0] OFF_LEGACY_PORT = 10'h000;
  localparam logic [9:0] OFF_A20_CTRL = 10'h100;
  localparam logic [9:0] OFF_KBD_CTRL = 10'h108;
  localparam logic [9:0] OFF_A20_SET = 10'h108;
  localparam logic [9:0] OFF_A20_CLR = 10'h10c;
  localparam logic [9:0] OFF_AUX_DATA = 10'h10c;
  localparam logic [9:0] OFF_KBD_DATA = 10'h100;
  localparam logic [9:0] OFF_KBD_LATCH = 10'h114;
  localparam logic [9:0] OFF_PORT_EN = 10'h330;
  localparam logic [7:0] HOST_IO_LEGACY = 8'h92;
  localparam logic [7:0] CFG_IDX_PORT_EN = 8'h30;
  localparam logic [7:0] CMD_A20_WRITE = 8'hd1;
  localparam logic [7:0] RST_LEGACY_PORT = 8'h00;
  localparam logic [7:0] RST_KBD_CTRL = 8'h00;
  localparam logic [7:0] RST_PORT_EN = 8'h00;
  localparam int BIT_AUX_HW = 7;
  localparam int BIT_IRQ_GATE = 5;
  localparam int BIT_KBD_FW_SEL = 2;
  localparam int BIT_FW_A20 = 1;
  localparam int BIT_FAST_RST = 0;
  localparam int BIT_ALT_ADDR20 = 1;
  localparam int CLK_MHZ = 100;
  localparam int FAST_RST_DELAY_US = 14;
  localparam int FAST_RST_PULSE_US = 6;
  localparam int FAST_RST_DELAY_CYC = FAST_RST_DELAY_US * CLK_MHZ;
  localparam int FAST_RST_PULSE_CYC = FAST_RST_PULSE_US * CLK_MHZ;
endpackage

// ---- hdl/fast_reset_timer.sv ----
// Delayed low pulse generator, re-armed only after the request drops.
module fast_reset_timer
  import kbd_legacy_pkg::*;
#(
  parameter int DELAY_CYC = FAST_RST_DELAY_CYC,
  parameter int PULSE_CYC = FAST_RST_PULSE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic request_in,
  output logic pulse_n_out
);
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_PULSE = 2'b10,
    T_HOLD = 2'b11
  } timer_state_e;

  initial begin
    if (DELAY_CYC < 1 || PULSE_CYC < 1 || DELAY_CYC > 65535 ||
        PULSE_CYC > 65535) begin
      $error("fast_reset_timer: counts out of range");
    end
  end

  timer_state_e state_r;
  logic [15:0] count_r;

  // Delay, pulse, then hold until the request bit is cleared.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= T_IDLE;
      count_r <= 16'h0000;
    end else begin
      case (state_r)
        T_IDLE: begin
          if (request_in) begin
            state_r <= T_WAIT;
            count_r <= 16'(DELAY_CYC - 1);
          end
        end
        T_WAIT: begin
          if (count_r == 16'h0000) begin
            state_r <= T_PULSE;
            count_r <= 16'(PULSE_CYC - 1);
          end else begin
            count_r <= count_r - 16'h0001;
          end
        end
        T_PULSE: begin
          if (count_r == 16'h0000) begin
            state_r <= T_HOLD;
          end else begin
            count_r <= count_r - 16'h0001;
          end
        end
        T_HOLD: begin
          if (!request_in) begin
            state_r <= T_IDLE;
          end
        end
        default: state_r <= T_IDLE;
      endcase
    end
  end

  // Pulse output is registered to stay glitch free.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_n_out <= 1'b1;
    end else begin
      pulse_n_out <= !((state_r == T_WAIT && count_r == 16'h0000) ||
                       (state_r == T_PULSE && count_r != 16'h0000));
    end
  end
endmodule // fast_reset_timer

// ---- hdl/keyboard_legacy_control.sv ----
// Keyboard control register and legacy port logic.
module keyboard_legacy_control
  import kbd_legacy_pkg::*;
#(
  parameter int DELAY_CYC = FAST_RST_DELAY_CYC,
  parameter int PULSE_CYC = FAST_RST_PULSE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic io_block_reset_n_in,
  // Controller peripheral bus.
  input wire logic [9:0] ec_addr_in,
  input wire logic ec_write_in,
  input wire logic ec_read_in,
  input wire logic [7:0] ec_wdata_in,
  output logic [7:0] ec_rdata_out,
  // Host I/O and configuration access.
  input wire logic [7:0] host_addr_in,
  input wire logic host_io_write_in,
  input wire logic host_io_read_in,
  input wire logic host_cfg_write_in,
  input wire logic host_cfg_read_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  output logic host_rdata_oe_out,
  // Host interface events from the data path.
  input wire logic host_data_read_in,
  input wire logic host_cmd_valid_in,
  input wire logic host_data_valid_in,
  input wire logic [7:0] host_byte_in,
  input wire logic output_buffer_full_in,
  input wire logic kbd_reset_req_in,
  // Outputs.
  output logic aux_output_full_out,
  output logic kbd_irq_line_out,
  output logic mouse_irq_line_out,
  output logic addr20_gate_out,
  output logic fast_reset_pulse_n_out,
  output logic cpu_reset_out
);
  logic sys_rst_n;
  assign sys_rst_n = rst_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Matches a controller write at a given offset.
  function automatic logic ec_wr_at(input logic [9:0] off);
    return ec_write_in && ec_addr_in == off;
  endfunction

  logic [7:0] kbd_ctrl_r;
  logic port_en_r;
  logic [7:0] legacy_port_r;
  logic fw_a20_r;
  logic host_a20_r;
  logic kbd_data_flag_r;
  logic kbd_fw_latch_r;
  logic aux_full_r;
  logic aux_irq_flag_r;
  logic cmd_d1_pending_r;
  logic kbd_output_full_line;
  logic port_hit;

  assign port_hit = host_addr_in == HOST_IO_LEGACY;

  ////////////////////////////////////////////////////////////////////////////
  // Keyboard control register.

  // Fully firmware writable on the system reset.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      kbd_ctrl_r <= RST_KBD_CTRL;
    end else if (ec_wr_at(OFF_KBD_CTRL)) begin
      kbd_ctrl_r <= ec_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port enable register, bit 0 only, other bits read zero.

  // Writable by host configuration and by the controller.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      port_en_r <= RST_PORT_EN[0];
    end else if (host_cfg_write_in && host_addr_in == CFG_IDX_PORT_EN) begin
      port_en_r <= host_wdata_in[0];
    end else if (ec_wr_at(OFF_PORT_EN)) begin
      port_en_r <= ec_wdata_in[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Legacy port register on the io-block reset.

  // Only bits 0 and 1 are storage; host writes need the port enabled.
  always_ff @(posedge clock_in or negedge io_block_reset_n_in) begin
    if (!io_block_reset_n_in) begin
      legacy_port_r <= RST_LEGACY_PORT;
    end else if (host_io_write_in && port_hit && port_en_r) begin
      legacy_port_r <= {6'h00, host_wdata_in[1:0]};
    end else if (ec_wr_at(OFF_LEGACY_PORT)) begin
      legacy_port_r <= {6'h00, ec_wdata_in[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address-20 latches.

  // Firmware gate bit, used when firmware assist is on.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      fw_a20_r <= 1'b0;
    end else if (ec_wr_at(OFF_A20_CTRL)) begin
      fw_a20_r <= ec_wdata_in[0];
    end
  end

  // Host latch: strobes from the controller, command D1 from the host.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      host_a20_r <= 1'b1;
      cmd_d1_pending_r <= 1'b0;
    end else begin
      if (ec_wr_at(OFF_A20_SET)) begin
        host_a20_r <= 1'b1;
      end else if (ec_wr_at(OFF_A20_CLR)) begin
        host_a20_r <= 1'b0;
      end else if (host_data_valid_in && cmd_d1_pending_r) begin
        host_a20_r <= host_byte_in[1];
      end
      if (host_cmd_valid_in) begin
        cmd_d1_pending_r <= host_byte_in == CMD_A20_WRITE;
      end else if (host_data_valid_in) begin
        cmd_d1_pending_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output-full flags.

  // Keyboard data flag: set by data write, cleared by host read; set wins.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      kbd_data_flag_r <= 1'b0;
      kbd_fw_latch_r <= 1'b0;
    end else begin
      if (ec_wr_at(OFF_KBD_DATA)) begin
        kbd_data_flag_r <= 1'b1;
      end else if (host_data_read_in) begin
        kbd_data_flag_r <= 1'b0;
      end
      if (ec_wr_at(OFF_KBD_LATCH)) begin
        kbd_fw_latch_r <= ec_wdata_in[0];
      end
    end
  end

  // Aux status bit and aux interrupt flag.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      aux_full_r <= 1'b0;
      aux_irq_flag_r <= 1'b0;
    end else begin
      if (kbd_ctrl_r[BIT_AUX_HW]) begin
        if (ec_wr_at(OFF_AUX_DATA)) begin
          aux_full_r <= 1'b1;
        end else if (host_data_read_in) begin
          aux_full_r <= 1'b0;
        end
      end else if (ec_wr_at(OFF_KBD_CTRL)) begin
        aux_full_r <= ec_wdata_in[6];
      end
      if (ec_wr_at(OFF_AUX_DATA)) begin
        aux_irq_flag_r <= 1'b1;
      end else if (host_data_read_in) begin
        aux_irq_flag_r <= 1'b0;
      end
    end
  end

  assign kbd_output_full_line = kbd_ctrl_r[BIT_KBD_FW_SEL] ?
      kbd_fw_latch_r : kbd_data_flag_r;

  // Interrupt lines gated by the control bit; firmware keeps it stable
  // while output_buffer_full_in is high.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      kbd_irq_line_out <= 1'b0;
      mouse_irq_line_out <= 1'b0;
      aux_output_full_out <= 1'b0;
    end else begin
      kbd_irq_line_out <= kbd_ctrl_r[BIT_IRQ_GATE] &&
                          kbd_output_full_line;
      mouse_irq_line_out <= kbd_ctrl_r[BIT_IRQ_GATE] &&
                            aux_irq_flag_r;
      aux_output_full_out <= aux_full_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address-20 gate output.

  // Firmware bit wins when assist is on; otherwise host latch or alt bit.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      addr20_gate_out <= 1'b1;
    end else if (kbd_ctrl_r[BIT_FW_A20]) begin
      addr20_gate_out <= fw_a20_r;
    end else begin
      addr20_gate_out <= host_a20_r ||
          (port_en_r && legacy_port_r[BIT_ALT_ADDR20]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast reset.

  logic fast_req;
  assign fast_req = port_en_r && legacy_port_r[BIT_FAST_RST];

  fast_reset_timer #(
    .DELAY_CYC(DELAY_CYC),
    .PULSE_CYC(PULSE_CYC)
  ) u_timer (
    .clock_in(clock_in),
    .rst_n_in(sys_rst_n),
    .request_in(fast_req),
    .pulse_n_out(fast_reset_pulse_n_out)
  );

  // Processor reset combines both reset sources.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      cpu_reset_out <= 1'b0;
    end else begin
      cpu_reset_out <= !fast_reset_pulse_n_out || kbd_reset_req_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read paths, registered one cycle after the strobe.

  // Controller reads; unmapped offsets read zero.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ec_rdata_out <= 8'h00;
    end else if (ec_read_in) begin
      case (ec_addr_in)
        OFF_LEGACY_PORT: ec_rdata_out <= legacy_port_r;
        OFF_A20_CTRL: ec_rdata_out <= {7'h00, kbd_ctrl_r[BIT_FW_A20] ?
                                       fw_a20_r : host_a20_r};
        OFF_KBD_CTRL: ec_rdata_out <= {kbd_ctrl_r[7], aux_full_r,
                                       kbd_ctrl_r[5:0]};
        OFF_KBD_LATCH: ec_rdata_out <= {7'h00, kbd_output_full_line};
        OFF_PORT_EN: ec_rdata_out <= {7'h00, port_en_r};
        default: ec_rdata_out <= 8'h00;
      endcase
    end
  end

  // Host reads; the port leaves the bus undriven when disabled.
  always_ff @(posedge clock_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      host_rdata_out <= 8'h00;
      host_rdata_oe_out <= 1'b0;
    end else if (host_io_read_in && port_hit && port_en_r) begin
      host_rdata_out <= legacy_port_r;
      host_rdata_oe_out <= 1'b1;
    end else if (host_cfg_read_in && host_addr_in == CFG_IDX_PORT_EN) begin
      host_rdata_out <= {7'h00, port_en_r};
      host_rdata_oe_out <= 1'b1;
    end else begin
      host_rdata_out <= 8'h00;
      host_rdata_oe_out <= 1'b0;
    end
  end
endmodule // keyboard_legacy_control

// ---- bench/kbd_legacy_chk.sv ----
// Watches the keyboard legacy block from its ports only.
module kbd_legacy_chk
  import kbd_legacy_pkg::*;
#(
  parameter int DELAY_CYC = FAST_RST_DELAY_CYC,
  parameter int PULSE_CYC = FAST_RST_PULSE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [9:0] ec_addr_in,
  input wire logic ec_write_in,
  input wire logic [7:0] ec_wdata_in,
  input wire logic [7:0] host_addr_in,
  input wire logic host_io_read_in,
  input wire logic host_cfg_write_in,
  input wire logic host_cfg_read_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_rdata_oe_out,
  input wire logic kbd_reset_req_in,
  input wire logic aux_output_full_out,
  input wire logic kbd_irq_line_out,
  input wire logic mouse_irq_line_out,
  input wire logic addr20_gate_out,
  input wire logic fast_reset_pulse_n_out,
  input wire logic cpu_reset_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] ctl_r;
  logic en_r;
  logic [15:0] low_cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows of the control and enable bits, tracked from bus writes.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r <= RST_KBD_CTRL;
      en_r <= 1'b0;
    end else begin
      if (ec_write_in && ec_addr_in == OFF_KBD_CTRL)
        ctl_r <= ec_wdata_in;
      if (host_cfg_write_in && host_addr_in == CFG_IDX_PORT_EN)
        en_r <= host_wdata_in[0];
      else if (ec_write_in && ec_addr_in == OFF_PORT_EN)
        en_r <= ec_wdata_in[0];
    end
  end
  // Counts how many cycles the fast reset pulse has been low so far.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= fast_reset_pulse_n_out ? 16'h0000 : low_cnt_r + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_pulse_width: assert property (
    $rose(fast_reset_pulse_n_out) |-> low_cnt_r == PULSE_CYC)
    else $error("fast reset pulse has the wrong width");
  a_cpu_follow: assert property (
    !fast_reset_pulse_n_out |=> cpu_reset_out)
    else $error("processor reset missed the fast reset pulse");
  a_kbd_req_reset: assert property (
    kbd_reset_req_in |-> ##[1:2] cpu_reset_out)
    else $error("processor reset missed the keyboard request");
  a_irq_gate_off: assert property (
    !ctl_r[BIT_IRQ_GATE] |=> !kbd_irq_line_out && !mouse_irq_line_out)
    else $error("interrupt line high while gated off");
  a_aux_hw_set: assert property (
    ctl_r[BIT_AUX_HW] && ec_write_in && ec_addr_in == OFF_AUX_DATA
    |-> ##[1:2] aux_output_full_out)
    else $error("aux output full not set by aux data write");
  a_a20_set: assert property (
    ec_write_in && ec_addr_in == OFF_A20_SET && !ec_wdata_in[BIT_FW_A20]
    |-> ##[1:2] addr20_gate_out)
    else $error("set strobe did not raise the address-20 gate");
  a_port_off_read: assert property (
    host_io_read_in && host_addr_in == HOST_IO_LEGACY && !en_r
    |=> !host_rdata_oe_out)
    else $error("disabled legacy port drove the data bus");
  a_oe_cause: assert property (
    host_rdata_oe_out |-> $past(host_io_read_in) || $past(host_cfg_read_in))
    else $error("host data bus driven without a read");
endmodule // kbd_legacy_chk

bind keyboard_legacy_control kbd_legacy_chk #(
  .DELAY_CYC(DELAY_CYC), .PULSE_CYC(PULSE_CYC)
) chk_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .ec_addr_in(ec_addr_in),
  .ec_write_in(ec_write_in), .ec_wdata_in(ec_wdata_in),
  .host_addr_in(host_addr_in), .host_io_read_in(host_io_read_in),
  .host_cfg_write_in(host_cfg_write_in), .host_cfg_read_in(host_cfg_read_in),
  .host_wdata_in(host_wdata_in), .host_rdata_oe_out(host_rdata_oe_out),
  .kbd_reset_req_in(kbd_reset_req_in),
  .aux_output_full_out(aux_output_full_out),
  .kbd_irq_line_out(kbd_irq_line_out),
  .mouse_irq_line_out(mouse_irq_line_out),
  .addr20_gate_out(addr20_gate_out),
  .fast_reset_pulse_n_out(fast_reset_pulse_n_out),
  .cpu_reset_out(cpu_reset_out)
);

// ---- bench/host_partner.sv ----
// Host data path model: command and data bytes, data reads, reset requests.
module host_partner (
  input wire logic clock_in,
  output logic data_read_out,
  output logic cmd_valid_out,
  output logic data_valid_out,
  output logic [7:0] byte_out,
  output logic obf_out,
  output logic reset_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle values at time zero.
  initial begin
    {data_read_out, cmd_valid_out, data_valid_out} = 3'h0;
    {obf_out, reset_req_out} = 2'h0;
    byte_out = 8'h00;
  end
  // Sends one byte; the byte bus shows garbage once the strobe drops.
  task automatic put(input bit is_cmd, input logic [7:0] b);
    @(posedge clock_in);
    byte_out <= b;
    cmd_valid_out <= is_cmd;
    data_valid_out <= !is_cmd;
    @(posedge clock_in);
    {cmd_valid_out, data_valid_out} <= 2'h0;
    byte_out <= ~b;
  endtask
  // Host read of the data register, which empties the output flags.
  task automatic rd();
    @(posedge clock_in);
    data_read_out <= 1'b1;
    @(posedge clock_in);
    data_read_out <= 1'b0;
  endtask
  // Sets the buffer-full level and the keyboard reset request level.
  task automatic lvl(input bit o, input bit r);
    @(posedge clock_in);
    obf_out <= o;
    reset_req_out <= r;
  endtask
endmodule // host_partner

// ---- bench/tb_top.sv ----
// Register-level bench for the keyboard legacy block.
module tb_top
  import kbd_legacy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 5;
  localparam int PLS = 3;
  localparam int AUX = 0, KI = 1, MI = 2, GT = 3, CPU = 5;
  logic clock_in, rst_n_in, io_rst_n, ec_wr, ec_rd;
  logic [9:0] ec_addr;
  logic [7:0] ec_wdata, ec_rdata, h_addr, h_wdata, h_rdata, hbyte;
  logic h_iow, h_ior, h_cfgw, h_cfgr, h_oe, hd_rd, hc_v, hd_v, output_buffer_full, kreq;
  logic aux_full, kbd_irq_line, mouse_irq_line, gate, pulse_n, cpu_rst;
  logic [5:0] outs;
  int miscompares, n_compared, cyc;
  assign outs = {cpu_rst, pulse_n, gate, mouse_irq_line, kbd_irq_line, aux_full};
  ////////////////////////////////////////////////////////////////////////////
  keyboard_legacy_control #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) DUT (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .io_block_reset_n_in(io_rst_n),
    .ec_addr_in(ec_addr), .ec_write_in(ec_wr), .ec_read_in(ec_rd),
    .ec_wdata_in(ec_wdata), .ec_rdata_out(ec_rdata), .host_addr_in(h_addr),
    .host_io_write_in(h_iow), .host_io_read_in(h_ior),
    .host_cfg_write_in(h_cfgw), .host_cfg_read_in(h_cfgr),
    .host_wdata_in(h_wdata), .host_rdata_out(h_rdata),
    .host_rdata_oe_out(h_oe), .host_data_read_in(hd_rd),
    .host_cmd_valid_in(hc_v), .host_data_valid_in(hd_v),
    .host_byte_in(hbyte), .output_buffer_full_in(output_buffer_full),
    .kbd_reset_req_in(kreq), .aux_output_full_out(aux_full),
    .kbd_irq_line_out(kbd_irq_line), .mouse_irq_line_out(mouse_irq_line),
    .addr20_gate_out(gate), .fast_reset_pulse_n_out(pulse_n),
    .cpu_reset_out(cpu_rst));
  host_partner hp (.clock_in(clock_in), .data_read_out(hd_rd),
    .cmd_valid_out(hc_v), .data_valid_out(hd_v), .byte_out(hbyte),
    .obf_out(output_buffer_full), .reset_req_out(kreq));
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Controller bus write, one-cycle strobe.
  task automatic ew(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock_in);
    ec_addr <= a;
    ec_wdata <= d;
    ec_wr <= 1'b1;
    @(posedge clock_in);
    ec_wr <= 1'b0;
  endtask
  // Controller bus read; data is settled just after the taking edge.
  task automatic er(input logic [9:0] a, input logic [7:0] e);
    @(posedge clock_in);
    ec_addr <= a;
    ec_rd <= 1'b1;
    @(posedge clock_in);
    ec_rd <= 1'b0;
    #1;
    chk({1'b0, ec_rdata}, {1'b0, e});
  endtask
  // Host access: 0 io write, 1 io read, 2 config write, 3 config read.
  task automatic hx(input int k, input logic [7:0] a, input logic [7:0] d,
                    input logic [8:0] e);
    @(posedge clock_in);
    h_addr <= a;
    h_wdata <= d;
    {h_cfgr, h_cfgw, h_ior, h_iow} <= 4'h1 << k;
    @(posedge clock_in);
    {h_cfgr, h_cfgw, h_ior, h_iow} <= 4'h0;
    #1;
    if (k[0]) chk({h_oe, h_oe ? h_rdata : 8'h00}, e);
  endtask
  // Lets a few cycles pass, then checks one output level.
  task automatic wc(input int i, input bit e);
    repeat (3) @(posedge clock_in);
    #1;
    chk({8'h00, outs[i]}, {8'h00, e});
  endtask
  // Measures delay and width of the fast reset pulse, if any.
  task automatic pulse_chk(input bit e);
    int k, w;
    k = 0;
    w = 0;
    while (pulse_n === 1'b1 && k < 40) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    while (pulse_n === 1'b0 && w < 40) begin
      @(posedge clock_in);
      #1;
      w++;
    end
    chk(9'(k), e ? 9'(DLY + 1) : 9'd40);
    chk(9'(w), e ? 9'(PLS) : 9'd0);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock.
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Cuts a hang short.
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence.
  initial begin
    {rst_n_in, io_rst_n, ec_wr, ec_rd, h_iow, h_ior, h_cfgw, h_cfgr} = 8'h00;
    {ec_addr, ec_wdata, h_addr, h_wdata} = 34'h0;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    io_rst_n <= 1'b1;
    er(OFF_KBD_CTRL, RST_KBD_CTRL);
    er(OFF_PORT_EN, RST_PORT_EN);
    er(10'h3fc, 8'h00);
    hx(0, HOST_IO_LEGACY, 8'h02, 9'h0);
    hx(1, HOST_IO_LEGACY, 8'h00, 9'h000);
    er(OFF_LEGACY_PORT, 8'h00);
    hx(2, CFG_IDX_PORT_EN, 8'hff, 9'h0);
    hx(3, CFG_IDX_PORT_EN, 8'h00, 9'h101);
    er(OFF_PORT_EN, 8'h01);
    hx(0, HOST_IO_LEGACY, 8'h02, 9'h0);
    hx(1, HOST_IO_LEGACY, 8'h00, 9'h102);
    hx(1, 8'h93, 8'h00, 9'h000);
    ew(OFF_A20_CLR, 8'hff);
    wc(GT, 1);
    hx(0, HOST_IO_LEGACY, 8'h00, 9'h0);
    wc(GT, 0);
    ew(OFF_A20_SET, 8'h00);
    wc(GT, 1);
    ew(OFF_KBD_CTRL, 8'h20);
    hp.put(1'b1, CMD_A20_WRITE);
    hp.put(1'b0, 8'hfd);
    wc(GT, 0);
    wc(KI, 0);
    hp.put(1'b1, CMD_A20_WRITE);
    hp.put(1'b0, 8'h02);
    wc(GT, 1);
    ew(OFF_KBD_CTRL, 8'h22);
    ew(OFF_A20_CTRL, 8'h00);
    wc(GT, 0);
    wc(KI, 1);
    ew(OFF_A20_CTRL, 8'h01);
    wc(GT, 1);
    ew(OFF_A20_CLR, 8'h00);
    wc(MI, 1);
    wc(AUX, 0);
    ew(OFF_KBD_CTRL, 8'h20);
    ew(OFF_A20_CLR, 8'h00);
    wc(GT, 0);
    ew(OFF_KBD_CTRL, 8'h24);
    ew(OFF_KBD_LATCH, 8'h00);
    wc(KI, 0);
    ew(OFF_KBD_LATCH, 8'h01);
    wc(KI, 1);
    hp.rd();
    ew(OFF_KBD_CTRL, 8'h04);
    ew(OFF_KBD_LATCH, 8'h01);
    wc(KI, 0);
    ew(OFF_KBD_CTRL, 8'ha0);
    ew(OFF_AUX_DATA, 8'h5a);
    wc(AUX, 1);
    hx(0, HOST_IO_LEGACY, 8'h01, 9'h0);
    pulse_chk(1'b1);
    hx(0, HOST_IO_LEGACY, 8'h01, 9'h0);
    pulse_chk(1'b0);
    hx(0, HOST_IO_LEGACY, 8'h00, 9'h0);
    hx(0, HOST_IO_LEGACY, 8'h01, 9'h0);
    pulse_chk(1'b1);
    hp.lvl(1'b0, 1'b1);
    wc(CPU, 1);
    hp.lvl(1'b0, 1'b0);
    wc(CPU, 0);
    @(posedge clock_in);
    io_rst_n <= 1'b0;
    @(posedge clock_in);
    io_rst_n <= 1'b1;
    er(OFF_LEGACY_PORT, RST_LEGACY_PORT);
    er(OFF_KBD_CTRL, 8'he0);
    close_out();
  end
endmodule // tb_top
